//--- hw/rxal_pkg.sv
// Types shared by the receive frequency and gain loop controller
package rxal_pkg;

	typedef enum logic [2:0] {
		RXAL_G_IDLE = 3'b001,
		RXAL_G_MEAS = 3'b010,
		RXAL_G_HOLD = 3'b100
	} rxal_gstate_t;

	typedef enum logic [1:0] {
		RXAL_MOD_2FSK = 2'h0,
		RXAL_MOD_4FSK = 2'h1,
		RXAL_MOD_OOK = 2'h2,
		RXAL_MOD_ASK = 2'h3
	} rxal_mod_t;

endpackage

//--- hw/rxal_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RXAL_MAP_SVH
`define RXAL_MAP_SVH

`define RXAL_OFF_FREQ_CTRL 12'h000
`define RXAL_OFF_FREQ_GAIN 12'h004
`define RXAL_OFF_FAST_PER 12'h008
`define RXAL_OFF_PWR_TH 12'h00c
`define RXAL_OFF_FREQ_EST 12'h010
`define RXAL_OFF_GAIN_CTRL 12'h014
`define RXAL_OFF_HIGH_TH 12'h018
`define RXAL_OFF_LOW_TH 12'h01c
`define RXAL_OFF_GAIN_TIME 12'h020
`define RXAL_OFF_STATUS 12'h024

`define RXAL_BIT_FREQ_EN 0
`define RXAL_BIT_FREQ_MODE 1
`define RXAL_BIT_GAIN_EN 0
`define RXAL_BIT_FREEZE 1

`define RXAL_RST_SLOW_GAIN 4'h5
`define RXAL_RST_FAST_GAIN 4'h2
`define RXAL_RST_FAST_PER 8'h00
`define RXAL_RST_PWR_TH 8'h40
`define RXAL_RST_HIGH_TH 4'h5
`define RXAL_RST_LOW_TH0 4'h5
`define RXAL_RST_LOW_TH1 4'h4
`define RXAL_RST_LOW_SEL 8'h10
`define RXAL_RST_MEAS 4'h2
`define RXAL_RST_HOLD 8'h0c

`define RXAL_TICK_CLKS 20'd12
`define RXAL_STEP_DB 6
`define RXAL_MAX_DB 48
`define RXAL_MAX_STEP 4'(`RXAL_MAX_DB / `RXAL_STEP_DB)

`endif

//--- hw/rxal_loop_ctrl.sv
// Receive frequency compensation and gain control loops with AXI4-Lite registers
`timescale 1ns/1ps
`include "rxal_map.svh"

module rxal_loop_ctrl #(
	parameter int FW = 12
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Demodulator datapath
	input wire logic demod_valid,
	input wire logic signed [FW-1:0] demod_freq,
	input wire logic [7:0] rssi_level,
	input wire logic sync_det,
	input wire logic rx_restart,
	input wire logic amp_valid,
	input wire logic [3:0] amp_level,
	// Loop outputs
	output logic signed [FW-1:0] slicer_offset,
	output logic signed [FW-1:0] if2_offset,
	output logic freq_fast_mode,
	output logic [3:0] atten_step
);

	// ****************************************
	// Register decode
	// ****************************************
	function automatic logic [3:0] reg_sel(input logic [11:0] a);
		case (a)
			`RXAL_OFF_FREQ_CTRL: reg_sel = 4'h0;
			`RXAL_OFF_FREQ_GAIN: reg_sel = 4'h1;
			`RXAL_OFF_FAST_PER: reg_sel = 4'h2;
			`RXAL_OFF_PWR_TH: reg_sel = 4'h3;
			`RXAL_OFF_FREQ_EST: reg_sel = 4'h4;
			`RXAL_OFF_GAIN_CTRL: reg_sel = 4'h5;
			`RXAL_OFF_HIGH_TH: reg_sel = 4'h6;
			`RXAL_OFF_LOW_TH: reg_sel = 4'h7;
			`RXAL_OFF_GAIN_TIME: reg_sel = 4'h8;
			`RXAL_OFF_STATUS: reg_sel = 4'h9;
			default: reg_sel = 4'hf;
		endcase
	endfunction

	// Step 8 has no own select bit and reuses the top one
	function automatic logic [3:0] pick_low(input logic [7:0] sel, input logic [3:0] st,
		input logic [3:0] t0, input logic [3:0] t1);
		logic [2:0] i;
		i = (st > 4'd7) ? 3'd7 : st[2:0];
		pick_low = sel[i] ? t1 : t0;
	endfunction

	logic freq_en_q, freq_mode_q, gain_en_q, freeze_q;
	logic [1:0] mod_type_q;
	logic [3:0] slow_gain_q, fast_gain_q, high_th_q, low_th0_q, low_th1_q, meas_time_q;
	logic [7:0] fast_per_q, pwr_th_q, low_sel_q, hold_time_q;
	logic signed [FW-1:0] est_q, max_q, min_q;
	logic active_q, fast_q, sync_seen_q, low_ok_q;
	logic [7:0] fast_cnt_q;
	logic [19:0] gcnt_q;
	logic [3:0] atten_q;
	rxal_pkg::rxal_gstate_t gst_q;
	logic [3:0] wsel, rsel;
	logic wr_go, rd_go;
	logic [31:0] rd_word;

	assign wsel = reg_sel(s_axi_awaddr);
	assign rsel = reg_sel(s_axi_araddr);
	assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
	assign rd_go = s_axi_arready && s_axi_arvalid;

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (clk_en) begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wsel == 4'hf) ? 2'h2 : 2'h0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (clk_en) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rsel == 4'hf) ? 2'h2 : 2'h0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_word = 32'h0;
		case (rsel)
			4'h0: rd_word = {28'h0, mod_type_q, freq_mode_q, freq_en_q};
			4'h1: rd_word = {24'h0, fast_gain_q, slow_gain_q};
			4'h2: rd_word = {24'h0, fast_per_q};
			4'h3: rd_word = {24'h0, pwr_th_q};
			4'h4: rd_word = 32'(est_q);
			4'h5: rd_word = {30'h0, freeze_q, gain_en_q};
			4'h6: rd_word = {28'h0, high_th_q};
			4'h7: rd_word = {16'h0, low_sel_q, low_th1_q, low_th0_q};
			4'h8: rd_word = {16'h0, hold_time_q, 4'h0, meas_time_q};
			4'h9: rd_word = {25'h0, active_q, sync_seen_q, fast_q, atten_q};
			default: rd_word = 32'h0;
		endcase
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freq_en_q <= 1'b0;
			freq_mode_q <= 1'b0;
			mod_type_q <= 2'h0;
			slow_gain_q <= `RXAL_RST_SLOW_GAIN;
			fast_gain_q <= `RXAL_RST_FAST_GAIN;
			fast_per_q <= `RXAL_RST_FAST_PER;
			pwr_th_q <= `RXAL_RST_PWR_TH;
			gain_en_q <= 1'b0;
			freeze_q <= 1'b0;
			high_th_q <= `RXAL_RST_HIGH_TH;
			low_th0_q <= `RXAL_RST_LOW_TH0;
			low_th1_q <= `RXAL_RST_LOW_TH1;
			meas_time_q <= `RXAL_RST_MEAS;
		end else if (clk_en && wr_go && s_axi_wstrb[0]) begin
			case (wsel)
				4'h0: begin
					freq_en_q <= s_axi_wdata[`RXAL_BIT_FREQ_EN];
					freq_mode_q <= s_axi_wdata[`RXAL_BIT_FREQ_MODE];
					mod_type_q <= s_axi_wdata[3:2];
				end
				4'h1: begin
					slow_gain_q <= s_axi_wdata[3:0];
					fast_gain_q <= s_axi_wdata[7:4];
				end
				4'h2: fast_per_q <= s_axi_wdata[7:0];
				4'h3: pwr_th_q <= s_axi_wdata[7:0];
				4'h5: begin
					gain_en_q <= s_axi_wdata[`RXAL_BIT_GAIN_EN];
					freeze_q <= s_axi_wdata[`RXAL_BIT_FREEZE];
				end
				4'h6: high_th_q <= s_axi_wdata[3:0];
				4'h7: begin
					low_th0_q <= s_axi_wdata[3:0];
					low_th1_q <= s_axi_wdata[7:4];
				end
				4'h8: meas_time_q <= s_axi_wdata[3:0];
				default: begin
				end
			endcase
		end
	end

	// Upper byte lane fields, kept in their own process so each has one driver
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_sel_q <= `RXAL_RST_LOW_SEL;
			hold_time_q <= `RXAL_RST_HOLD;
		end else if (clk_en && wr_go && s_axi_wstrb[1]) begin
			if (wsel == 4'h7) begin
				low_sel_q <= s_axi_wdata[15:8];
			end
			if (wsel == 4'h8) begin
				hold_time_q <= s_axi_wdata[15:8];
			end
		end
	end

	// ****************************************
	// Frequency compensation loop
	// ****************************************
	logic afc_go, sample;
	logic signed [FW:0] center, err, step;

	assign afc_go = freq_en_q && (mod_type_q == rxal_pkg::RXAL_MOD_2FSK || mod_type_q == rxal_pkg::RXAL_MOD_4FSK);
	assign sample = demod_valid && active_q;
	assign center = ((FW+1)'(max_q) + (FW+1)'(min_q)) >>> 1;
	assign err = center - (FW+1)'(est_q);
	assign step = err >>> (fast_q ? fast_gain_q : slow_gain_q);

	// Sync flag: a sync arriving with restart is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_seen_q <= 1'b0;
		end else if (clk_en) begin
			if (sync_det) begin
				sync_seen_q <= 1'b1;
			end else if (rx_restart) begin
				sync_seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_q <= 1'b0;
			fast_q <= 1'b0;
			fast_cnt_q <= 8'h0;
		end else if (clk_en) begin
			if (!afc_go || rx_restart) begin
				active_q <= 1'b0;
				fast_q <= 1'b0;
			end else if (!active_q) begin
				if (rssi_level > pwr_th_q) begin
					active_q <= 1'b1;
					fast_q <= 1'b1;
					fast_cnt_q <= 8'h0;
				end
			end else if (fast_q) begin
				if (fast_per_q == 8'h0) begin
					if (sync_det) begin
						fast_q <= 1'b0;
					end
				end else if (demod_valid) begin
					fast_cnt_q <= fast_cnt_q + 8'h1;
					if (fast_cnt_q >= fast_per_q - 8'h1) begin
						fast_q <= 1'b0;
					end
				end
			end
		end
	end

	// Extremes leak back one LSB per sample so old peaks fade
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			est_q <= '0;
			max_q <= '0;
			min_q <= '0;
		end else if (clk_en) begin
			if (!afc_go) begin
				est_q <= '0;
				max_q <= '0;
				min_q <= '0;
			end else if (sample) begin
				max_q <= (demod_freq > max_q) ? demod_freq : max_q - FW'(1);
				min_q <= (demod_freq < min_q) ? demod_freq : min_q + FW'(1);
				est_q <= est_q + step[FW-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slicer_offset <= '0;
			if2_offset <= '0;
			freq_fast_mode <= 1'b0;
		end else if (clk_en) begin
			slicer_offset <= freq_mode_q ? '0 : est_q;
			if2_offset <= freq_mode_q ? est_q : '0;
			freq_fast_mode <= fast_q;
		end
	end

	// ****************************************
	// Gain control loop
	// ****************************************
	logic frozen, over_hi, under_lo_fail, meas_end;
	logic [19:0] meas_len, hold_len;
	logic [3:0] low_th;

	assign frozen = freeze_q && sync_seen_q;
	assign low_th = pick_low(low_sel_q, atten_q, low_th0_q, low_th1_q);
	assign over_hi = amp_valid && (amp_level > high_th_q);
	assign under_lo_fail = amp_valid && (amp_level >= low_th);
	assign meas_len = `RXAL_TICK_CLKS << meas_time_q;
	assign hold_len = 20'(`RXAL_TICK_CLKS * hold_time_q);
	assign meas_end = (gcnt_q + 20'h1 >= meas_len);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gst_q <= rxal_pkg::RXAL_G_IDLE;
			gcnt_q <= 20'h0;
			low_ok_q <= 1'b1;
			atten_q <= 4'h0;
		end else if (clk_en) begin
			if (!gain_en_q) begin
				gst_q <= rxal_pkg::RXAL_G_IDLE;
				atten_q <= 4'h0;
			end else if (!frozen) begin
				case (gst_q)
					rxal_pkg::RXAL_G_IDLE: begin
						gst_q <= rxal_pkg::RXAL_G_MEAS;
						gcnt_q <= 20'h0;
						low_ok_q <= 1'b1;
					end
					rxal_pkg::RXAL_G_MEAS: begin
						if (over_hi && atten_q < `RXAL_MAX_STEP) begin
							atten_q <= atten_q + 4'h1;
							gst_q <= rxal_pkg::RXAL_G_HOLD;
							gcnt_q <= 20'h0;
						end else if (meas_end) begin
							gcnt_q <= 20'h0;
							low_ok_q <= 1'b1;
							if (low_ok_q && !under_lo_fail && atten_q != 4'h0) begin
								atten_q <= atten_q - 4'h1;
								gst_q <= rxal_pkg::RXAL_G_HOLD;
							end
						end else begin
							gcnt_q <= gcnt_q + 20'h1;
							if (under_lo_fail) begin
								low_ok_q <= 1'b0;
							end
						end
					end
					rxal_pkg::RXAL_G_HOLD: begin
						if (gcnt_q + 20'h1 >= hold_len) begin
							gst_q <= rxal_pkg::RXAL_G_MEAS;
							gcnt_q <= 20'h0;
							low_ok_q <= 1'b1;
						end else begin
							gcnt_q <= gcnt_q + 20'h1;
						end
					end
					default: gst_q <= rxal_pkg::RXAL_G_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			atten_step <= 4'h0;
		end else if (clk_en) begin
			atten_step <= atten_q;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !clk_en);

	a_am_no_corr: assert property (!afc_go |=> est_q == '0)
		else $error("estimate not cleared outside FSK");
	a_slicer_route: assert property (!freq_mode_q |=> slicer_offset == $past(est_q) && if2_offset == '0)
		else $error("slicer correction misrouted");
	a_if_route: assert property (freq_mode_q |=> if2_offset == $past(est_q) && slicer_offset == '0)
		else $error("second IF correction misrouted");
	a_fast_start: assert property (afc_go && !rx_restart && !active_q && rssi_level > pwr_th_q
		|=> active_q && fast_q)
		else $error("fast mode did not start");
	a_fast_len: assert property (fast_q && active_q && afc_go && !rx_restart && demod_valid && fast_per_q != 8'h0
		&& fast_cnt_q == fast_per_q - 8'h1 |=> !fast_q)
		else $error("fast period end missed");
	a_sync_slow: assert property (fast_q && active_q && afc_go && !rx_restart && fast_per_q == 8'h0 && sync_det
		|=> !fast_q ##1 !fast_q)
		else $error("no slow gain after sync");
	a_atten_sat: assert property (atten_q <= `RXAL_MAX_STEP)
		else $error("attenuation above maximum");
	a_high_step: assert property (gain_en_q && !frozen && gst_q == rxal_pkg::RXAL_G_MEAS && over_hi
		&& atten_q < `RXAL_MAX_STEP |=> atten_q == $past(atten_q) + 4'h1 && gst_q == rxal_pkg::RXAL_G_HOLD)
		else $error("no step up above high threshold");
	a_low_step: assert property (gain_en_q && atten_q != 4'h0 && atten_q < $past(atten_q)
		|-> $past(meas_end && low_ok_q && !under_lo_fail))
		else $error("step down without full low interval");
	a_freeze_hold: assert property (gain_en_q && frozen |=> atten_q == $past(atten_q))
		else $error("attenuation moved while frozen");
	a_gain_off: assert property (!gain_en_q |=> atten_q == 4'h0 ##1 atten_step == 4'h0)
		else $error("gain loop active while disabled");

	c_fast_to_slow: cover property (fast_q ##1 !fast_q && active_q);
	c_atten_up: cover property (atten_q == 4'h0 ##1 atten_q == 4'h1);
	c_atten_down: cover property (atten_q == 4'h1 ##1 atten_q == 4'h0);
	c_reg_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);

endmodule

//--- dv/rxal_fe_model.sv
// Behavioural front end and demodulator feeding the loop controller
`timescale 1ns/1ps
module rxal_fe_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Stimulus from the bench
	input wire logic signed [11:0] freq_off,
	input wire logic [3:0] amp,
	input wire logic [7:0] rssi,
	input wire logic sync_req,
	input wire logic restart_req,
	// Datapath towards the controller
	output logic demod_valid,
	output logic signed [11:0] demod_freq,
	output logic [7:0] rssi_level,
	output logic sync_det,
	output logic rx_restart,
	output logic amp_valid,
	output logic [3:0] amp_level
);
	logic [1:0] ph_q;
	logic sync_q;
	logic rst_q;
	always_ff @(posedge aclk) begin
		ph_q <= aresetn ? ph_q + 2'h1 : 2'h0;
		sync_q <= sync_req;
		rst_q <= restart_req;
		rssi_level <= rssi;
		// One demodulator sample every fourth clock
		demod_valid <= aresetn && ph_q == 2'h3;
		// Off-sample data inverted so nothing leans on a stale value
		demod_freq <= (ph_q == 2'h3) ? freq_off : ~freq_off;
		amp_valid <= aresetn && ph_q[0];
		amp_level <= ph_q[0] ? amp : ~amp;
		sync_det <= sync_req && !sync_q;
		rx_restart <= restart_req && !rst_q;
	end
endmodule

//--- dv/tb.sv
// Self-checking bench for the receive loop controller
`timescale 1ns/1ps
`include "rxal_map.svh"
module tb;
	// ****
	// Signals and instances
	// ****
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic clk_en = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic demod_valid, sync_det, rx_restart, amp_valid, freq_fast_mode;
	logic signed [11:0] demod_freq, slicer_offset, if2_offset;
	logic [7:0] rssi_level;
	logic [3:0] amp_level, atten_step;
	logic signed [11:0] freq_off = 12'sh000;
	logic [3:0] amp = 4'h0;
	logic [7:0] rssi = 8'h00;
	logic sync_req = 1'b0, restart_req = 1'b0;
	int n_errors = 0, n_tests = 0, n_cyc = 0, n;

	always #2.5 aclk = ~aclk;

	rxal_loop_ctrl uut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .demod_valid, .demod_freq, .rssi_level, .sync_det, .rx_restart,
		.amp_valid, .amp_level, .slicer_offset, .if2_offset, .freq_fast_mode, .atten_step);

	rxal_fe_model fe (.aclk, .aresetn, .freq_off, .amp, .rssi, .sync_req, .restart_req, .demod_valid,
		.demod_freq, .rssi_level, .sync_det, .rx_restart, .amp_valid, .amp_level);

	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, e);
		chk(s_axi_rresp, er);
	endtask

	// Cycles until the attenuation index moves, bounded
	task automatic wait_step(output int k);
		logic [3:0] prev;
		prev = atten_step;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (atten_step === prev && k < 500);
	endtask

	task automatic pulse(input logic s);
		if (s) sync_req <= 1'b1;
		else restart_req <= 1'b1;
		cyc(2);
		sync_req <= 1'b0;
		restart_req <= 1'b0;
	endtask

	// Cut a hang short
	always @(posedge aclk) begin
		n_cyc++;
		if (n_cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	// ****
	// Tests
	// ****
	initial begin
		cyc(5);
		aresetn <= 1'b1;
		rd(`RXAL_OFF_FREQ_GAIN, 32'h25, 32'hff, 2'h0);
		rd(`RXAL_OFF_FAST_PER, 32'h0, 32'hff, 2'h0);
		rd(`RXAL_OFF_HIGH_TH, 32'h5, 32'hf, 2'h0);
		rd(`RXAL_OFF_LOW_TH, 32'h1045, 32'hffff, 2'h0);
		rd(`RXAL_OFF_GAIN_TIME, 32'hc02, 32'hff0f, 2'h0);
		rd(12'h100, 32'h0, 32'hffffffff, 2'h2);
		wr(12'h100, 32'h1, 2'h2);
		wr(`RXAL_OFF_HIGH_TH, 32'hf, 2'h0);
		rd(`RXAL_OFF_HIGH_TH, 32'hf, 32'hf, 2'h0);
		wr(`RXAL_OFF_HIGH_TH, 32'h5, 2'h0);
		// Short intervals: 12 clocks of measuring, 12 of hold; steady amplitude has no zero runs
		wr(`RXAL_OFF_GAIN_TIME, 32'h100, 2'h0);
		amp <= 4'hf;
		cyc(30);
		chk(atten_step, 4'h0);
		wr(`RXAL_OFF_GAIN_CTRL, 32'h1, 2'h0);
		wait_step(n);
		wait_step(n);
		chk(n >= 12 && n <= 16, 1'b1);
		cyc(150);
		chk(atten_step, 4'h8);
		amp <= 4'h4;
		wait_step(n);
		chk(atten_step, 4'h7);
		wait_step(n);
		chk(n >= 24 && n <= 28, 1'b1);
		cyc(150);
		chk(atten_step, 4'h4);
		amp <= 4'h5;
		cyc(100);
		chk(atten_step, 4'h4);
		amp <= 4'h0;
		cyc(300);
		chk(atten_step, 4'h0);
		amp <= 4'h5;
		wr(`RXAL_OFF_GAIN_CTRL, 32'h3, 2'h0);
		pulse(1'b1);
		amp <= 4'hf;
		cyc(100);
		chk(atten_step, 4'h0);
		pulse(1'b0);
		cyc(40);
		chk(atten_step != 4'h0, 1'b1);
		// Clock enable low must freeze the loop while it is still climbing
		clk_en <= 1'b0;
		cyc(1);
		n = atten_step;
		cyc(40);
		chk(atten_step, n);
		clk_en <= 1'b1;
		cyc(1);
		wr(`RXAL_OFF_GAIN_CTRL, 32'h0, 2'h0);
		cyc(5);
		chk(atten_step, 4'h0);
		// Frequency loop on a constant positive offset
		rssi <= 8'h40;
		freq_off <= 12'sh064;
		wr(`RXAL_OFF_FAST_PER, 32'h4, 2'h0);
		wr(`RXAL_OFF_FREQ_CTRL, 32'h1, 2'h0);
		cyc(40);
		chk(freq_fast_mode, 1'b0);
		rssi <= 8'h41;
		cyc(4);
		chk(freq_fast_mode, 1'b1);
		cyc(40);
		chk(freq_fast_mode, 1'b0);
		cyc(60);
		chk(slicer_offset > 0, 1'b1);
		chk(if2_offset, 12'h000);
		rd(`RXAL_OFF_FREQ_EST, 32'h0, 32'h80000000, 2'h0);
		rd(`RXAL_OFF_STATUS, 32'h40, 32'h70, 2'h0);
		wr(`RXAL_OFF_FREQ_CTRL, 32'h3, 2'h0);
		cyc(100);
		chk(if2_offset > 0, 1'b1);
		chk(slicer_offset, 12'h000);
		for (int i = 2; i < 4; i++) begin
			wr(`RXAL_OFF_FREQ_CTRL, 32'(i * 4 + 1), 2'h0);
			cyc(100);
			chk({slicer_offset, if2_offset}, 24'h0);
		end
		wr(`RXAL_OFF_FREQ_CTRL, 32'h5, 2'h0);
		cyc(100);
		chk(slicer_offset > 0, 1'b1);
		wr(`RXAL_OFF_FAST_PER, 32'h0, 2'h0);
		pulse(1'b0);
		cyc(80);
		chk(freq_fast_mode, 1'b1);
		pulse(1'b1);
		cyc(6);
		chk(freq_fast_mode, 1'b0);
		print_verdict();
	end
endmodule
